// file: hw/mode_pin_mux_and_irq_inputs.sv
`timescale 1ns/1ps

// Functional notes
// RL1 - maskable request recognised on falling edge or low level, chosen by config bit
// RL2 - reset forces the maskable request back to level recognition
// RL3 - reset sets nonmaskable mask flag; nonmaskable requests ignored until software clears
// RL4 - nonmaskable request line is level sensitive, active low, shareable
// RL5 - each shared source drives open drain and holds low until acknowledged
// RL6 - with shared maskable line software keeps level recognition
// RL7 - line still low after service interrupts again once mask clears
// RL8 - mode pins sampled while reset is asserted choose one of four modes
// RL9 - instruction start marker is open drain, low during opcode fetch cycle
// RL10 - strobe-in pin is handshake input single-chip, address latch strobe expanded
// RL11 - external logic may latch low address with address latch strobe
// RL12 - strobe-out pin is handshake strobe single-chip, direction indicator expanded
// RL13 - direction indicator low for writes, high for reads
// RL14 - direction indicator stays low across back-to-back writes
// RL15 - internal read visibility drives internal read data on muxed port, indicator high
// RL16 - high port general outputs single-chip, address bits 8-15 expanded
// RL17 - muxed port general I/O single-chip, address then data bit n expanded
// RL18 - timer, serial and converter port functions unchanged across all modes
// RL19 - muxed port shows low address in address phase, data while phase clock high
// RL20 - timer port bits 0-2 are general inputs or capture inputs three, two, one
// RL21 - serial enabled: bit0 receive, bit1 transmit, bits 2-5 MISO MOSI SCK SS
// RL22 - sampled mode latched at reset release and held until next reset
// RL23 - edge request captured in pending flag cleared when interrupt taken
module mode_pin_mux_and_irq_inputs
    import pin_mux_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        mode_select_pin_a,
    input  wire logic        mode_select_pin_b,
    input  wire logic        maskable_request_line_n,
    input  wire logic        nonmaskable_request_line_n,
    input  wire logic        irq_edge_select,
    input  wire logic        irq_edge_write,
    input  wire logic        irq_mask,
    input  wire logic        nmi_mask_clear,
    input  wire logic        irq_taken,
    input  wire logic        nmi_taken,
    input  wire logic        internal_read_visibility,
    input  wire core_cycle_t core_cycle,
    input  wire logic [7:0]  internal_rdata,
    input  wire logic        gp_strobe_out,
    input  wire logic [7:0]  gp_high_out,
    input  wire port_drive_t gp_mux_drive,
    input  wire logic        handshake_strobe_in,
    input  wire logic [7:0]  mux_port_in,
    input  wire logic [2:0]  timer_port_in,
    input  wire logic        serial_enable,
    input  wire logic        serial_txd,
    input  wire logic        serial_mosi,
    input  wire logic        serial_sck,
    input  wire logic        serial_miso,
    input  wire logic        serial_dir_mosi_oe,
    input  wire logic        serial_dir_sck_oe,
    input  wire logic        serial_dir_miso_oe,
    input  wire logic [5:0]  gp_serial_out,
    input  wire logic [5:0]  gp_serial_oe,
    input  wire logic [5:0]  serial_port_in,
    input  wire logic [7:0]  converter_port_in,
    output logic             irq_request,
    output logic             nmi_request,
    output logic             irq_edge_mode,
    output logic             nmi_mask_flag,
    output op_mode_t         op_mode,
    output logic             instruction_start_marker_oe,
    output logic             instruction_start_marker_out,
    output logic             address_latch_strobe,
    output logic             address_latch_strobe_oe,
    output logic             strobe_in_level,
    output logic             strobe_out_pin,
    output logic [7:0]       high_port_out,
    output port_drive_t      mux_port_drive,
    output logic [7:0]       mux_data_in,
    output logic             bus_phase_clock,
    output logic [2:0]       capture_input,
    output logic [5:0]       serial_port_out,
    output logic [5:0]       serial_port_oe,
    output logic             serial_rxd,
    output logic             serial_miso_in,
    output logic             serial_mosi_in,
    output logic             serial_sck_in,
    output logic             serial_ss_n,
    output logic [7:0]       converter_inputs
);

    logic        irq_edge_reg;
    logic        irq_edge_next;
    logic        irq_prev_reg;
    logic        irq_pend_reg;
    logic        irq_pend_next;
    logic        nmi_mask_reg;
    logic        nmi_mask_next;
    logic [1:0]  mode_sample_reg;
    logic        in_reset_reg;
    op_mode_t    mode_reg;
    op_mode_t    mode_next;
    bus_phase_t  phase_reg;
    bus_phase_t  phase_next;
    core_cycle_t cyc_reg;
    logic        dir_reg;
    logic        dir_next;
    logic        handshake_strobe_out_out_reg;
    logic        as_oe_reg;
    logic        lir_oe_reg;
    logic        as_reg;
    logic        eclk_reg;
    logic [7:0]  hi_reg;
    port_drive_t mux_reg;
    port_drive_t mux_next;
    logic [7:0]  mux_in_reg;
    logic        irq_out_reg;
    logic        nmi_out_reg;
    logic        handshake_strobe_out_in_reg;
    logic [2:0]  cap_reg;
    logic [5:0]  ser_out_reg;
    logic [5:0]  ser_oe_reg;
    logic [5:0]  ser_in_reg;
    logic [7:0]  conv_reg;

    function automatic logic is_expanded(input op_mode_t m);
        return (m == MODE_EXPANDED) || (m == MODE_TEST);
    endfunction

    wire logic       expanded       = is_expanded(mode_reg);
    wire logic       expanded_next  = is_expanded(mode_next);
    wire logic       irq_fall       = irq_prev_reg && !maskable_request_line_n;
    wire logic       irq_level      = !maskable_request_line_n;
    wire logic       visible_read   = internal_read_visibility
                                      && (mode_reg != MODE_SINGLE_CHIP)
                                      && (mode_reg != MODE_EXPANDED);
    wire logic       drive_data     = cyc_reg.write
                                      || (cyc_reg.internal && visible_read);
    wire logic       start_cycle    = core_cycle.valid && (phase_reg != PH_ADDRESS);
    wire logic [7:0] addr_lo        = cyc_reg.addr[7:0];
    wire logic [7:0] data_byte      = cyc_reg.write ? cyc_reg.wdata : internal_rdata;

    // edge/level select; reset back to level
    assign irq_edge_next = irq_edge_write ? irq_edge_select : irq_edge_reg; // RL1
    // set wins over take
    assign irq_pend_next = irq_edge_reg && (irq_fall || (irq_pend_reg && !irq_taken)); // RL23
    // mask cleared only by software, never set again except by reset
    assign nmi_mask_next = nmi_mask_reg && !nmi_mask_clear; // RL3
    assign mode_next     = in_reset_reg ? op_mode_t'(mode_sample_reg) : mode_reg; // RL22

    // address phase then data phase, one core cycle each pair
    assign phase_next = start_cycle ? PH_ADDRESS
                      : (phase_reg == PH_ADDRESS) ? PH_DATA : PH_IDLE;

    // low on writes, high otherwise; held low between writes
    assign dir_next = start_cycle ? !core_cycle.write
                    : (phase_reg == PH_DATA || phase_reg == PH_ADDRESS) ? dir_reg
                    : (cyc_reg.write ? dir_reg : 1'b1); // RL13 RL14

    always_comb begin
        mux_next = gp_mux_drive; // RL17
        if (expanded) begin
            if (phase_next == PH_ADDRESS) begin
                mux_next.out = start_cycle ? core_cycle.addr[7:0] : addr_lo; // RL19
                mux_next.oe  = BYTE_ONES;
            end else if (phase_next == PH_DATA) begin
                mux_next.out = data_byte; // RL15
                mux_next.oe  = drive_data ? BYTE_ONES : BYTE_ZERO;
            end else begin
                mux_next.out = BYTE_ZERO;
                mux_next.oe  = BYTE_ZERO;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irq_edge_reg <= IRQ_EDGE_RESET; // RL2
            nmi_mask_reg <= NMI_MASK_RESET; // RL3
            irq_pend_reg <= 1'b0;
            irq_prev_reg <= 1'b1;
            in_reset_reg <= 1'b1;
        end else begin
            irq_edge_reg <= irq_edge_next;
            nmi_mask_reg <= nmi_mask_next;
            irq_pend_reg <= irq_pend_next;
            irq_prev_reg <= maskable_request_line_n;
            in_reset_reg <= 1'b0;
        end
    end

    // pins sampled every reset cycle, taken on the first cycle after release
    always_ff @(posedge clk) begin
        mode_sample_reg <= rst_n ? mode_sample_reg
                                 : {mode_select_pin_b, mode_select_pin_a}; // RL8
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mode_reg    <= MODE_BOOTSTRAP;
            irq_out_reg <= 1'b0;
            nmi_out_reg <= 1'b0;
        end else begin
            mode_reg    <= mode_next; // RL22
            // level request reasserts as soon as the mask clears
            irq_out_reg <= !irq_mask && (irq_edge_reg ? irq_pend_next : irq_level); // RL1 RL7
            nmi_out_reg <= !nmi_mask_reg && !nonmaskable_request_line_n
                           && !nmi_taken; // RL4 RL7
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            phase_reg  <= PH_IDLE;
            cyc_reg    <= '0;
            dir_reg    <= 1'b1;
            lir_oe_reg <= 1'b0;
            as_reg     <= 1'b0;
            eclk_reg   <= 1'b0;
            mux_reg    <= '0;
            hi_reg     <= BYTE_ZERO;
            handshake_strobe_out_out_reg <= 1'b1;
            as_oe_reg  <= 1'b0;
        end else begin
            // pin follows the mode that the next cycle runs in
            handshake_strobe_out_out_reg <= expanded_next ? dir_next : gp_strobe_out; // RL12
            as_oe_reg  <= expanded_next; // RL10
            phase_reg  <= phase_next;
            cyc_reg    <= start_cycle ? core_cycle : cyc_reg;
            dir_reg    <= dir_next;
            // pull low for the whole opcode-fetch bus cycle
            lir_oe_reg <= start_cycle ? core_cycle.opcode_fetch
                        : (phase_reg == PH_ADDRESS) && lir_oe_reg; // RL9
            as_reg     <= expanded && (phase_next == PH_ADDRESS); // RL10 RL11
            eclk_reg   <= phase_next == PH_DATA; // RL19
            mux_reg    <= mux_next;
            hi_reg     <= expanded ? (start_cycle ? core_cycle.addr[15:ADDR_HI_LSB]
                                                  : cyc_reg.addr[15:ADDR_HI_LSB])
                                   : gp_high_out; // RL16
        end
    end

    // mode-independent ports and input sampling; strobe-in level is forced low in expanded modes
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            handshake_strobe_out_in_reg <= 1'b0;
            mux_in_reg  <= BYTE_ZERO;
            cap_reg     <= 3'h0;
            ser_out_reg <= 6'h00;
            ser_oe_reg  <= 6'h00;
            ser_in_reg  <= 6'h3F;
            conv_reg    <= BYTE_ZERO;
        end else begin
            handshake_strobe_out_in_reg <= expanded ? 1'b0 : handshake_strobe_in; // RL10
            mux_in_reg  <= mux_port_in;
            cap_reg     <= {timer_port_in[0], timer_port_in[1], timer_port_in[2]}; // RL20 RL18
            ser_in_reg  <= serial_port_in;
            conv_reg    <= converter_port_in; // RL18
            if (serial_enable) begin
                ser_out_reg <= {1'b0, serial_sck, serial_mosi, serial_miso,
                                serial_txd, 1'b0}; // RL21
                ser_oe_reg  <= {1'b0, serial_dir_sck_oe, serial_dir_mosi_oe,
                                serial_dir_miso_oe, 1'b1, 1'b0}; // RL21
            end else begin
                ser_out_reg <= gp_serial_out;
                ser_oe_reg  <= gp_serial_oe;
            end
        end
    end

    assign irq_request                  = irq_out_reg;
    assign nmi_request                  = nmi_out_reg;
    assign irq_edge_mode                = irq_edge_reg;
    assign nmi_mask_flag                = nmi_mask_reg;
    assign op_mode                      = mode_reg;
    assign instruction_start_marker_oe  = lir_oe_reg;
    assign instruction_start_marker_out = 1'b0;
    assign address_latch_strobe         = as_reg;
    assign address_latch_strobe_oe      = as_oe_reg;
    assign strobe_in_level              = handshake_strobe_out_in_reg;
    assign strobe_out_pin               = handshake_strobe_out_out_reg;
    assign high_port_out                = hi_reg;
    assign mux_port_drive               = mux_reg;
    assign mux_data_in                  = mux_in_reg;
    assign bus_phase_clock              = eclk_reg;
    assign capture_input                = cap_reg;
    assign serial_port_out              = ser_out_reg;
    assign serial_port_oe               = ser_oe_reg;
    assign serial_rxd                   = ser_in_reg[RXD_BIT];
    assign serial_miso_in               = ser_in_reg[MISO_BIT];
    assign serial_mosi_in               = ser_in_reg[MOSI_BIT];
    assign serial_sck_in                = ser_in_reg[SCK_BIT];
    assign serial_ss_n                  = ser_in_reg[SS_BIT];
    assign converter_inputs             = conv_reg;

    a_irq_level_reset: assert property (@(posedge clk) !rst_n |=> !irq_edge_mode) // RL2
        else $error("maskable request not level after reset");
    a_nmi_mask_reset: assert property (@(posedge clk) !rst_n |=> nmi_mask_flag) // RL3
        else $error("nonmaskable mask not set by reset");
    a_nmi_masked_quiet: assert property (@(posedge clk) disable iff (!rst_n) // RL3
        $past(nmi_mask_flag) |-> !nmi_request)
        else $error("nonmaskable request passed while masked");
    a_nmi_level_req: assert property (@(posedge clk) disable iff (!rst_n) // RL4
        !nmi_mask_flag && !nonmaskable_request_line_n && !nmi_taken |=> nmi_request)
        else $error("nonmaskable level request missed");
    a_irq_level_req: assert property (@(posedge clk) disable iff (!rst_n) // RL7
        !irq_edge_mode && !irq_mask && !maskable_request_line_n |=> irq_request)
        else $error("level maskable request missed");
    a_mode_held: assert property (@(posedge clk) disable iff (!rst_n) // RL22
        $past(rst_n, 2) |-> $stable(op_mode))
        else $error("mode changed outside reset");
    a_dir_write_low: assert property (@(posedge clk) disable iff (!rst_n) // RL13
        start_cycle && core_cycle.write |=> !dir_reg [*2])
        else $error("direction indicator not low during write");
    a_dir_read_high: assert property (@(posedge clk) disable iff (!rst_n) // RL13
        start_cycle && !core_cycle.write |=> dir_reg)
        else $error("direction indicator not high during read");
    a_high_addr: assert property (@(posedge clk) disable iff (!rst_n) // RL16
        expanded && start_cycle |=> high_port_out == $past(core_cycle.addr[15:8]))
        else $error("high port does not carry upper address");
    a_as_phase: assert property (@(posedge clk) disable iff (!rst_n) // RL19
        address_latch_strobe |-> mux_port_drive.oe == BYTE_ONES)
        else $error("address strobe without address on muxed port");

    c_expanded_write: cover property (@(posedge clk) expanded && start_cycle && core_cycle.write);
    c_edge_irq: cover property (@(posedge clk) irq_edge_mode && irq_request);
    c_nmi_taken: cover property (@(posedge clk) nmi_request ##1 nmi_taken);
    c_visible_read: cover property (@(posedge clk) visible_read && phase_reg == PH_DATA);

endmodule

// file: shared/pin_mux_pkg.sv
package pin_mux_pkg;

    // operating modes, index = {mode_select_pin_b, mode_select_pin_a}
    typedef enum logic [1:0] {
        MODE_BOOTSTRAP   = 2'b00,
        MODE_SINGLE_CHIP = 2'b01,
        MODE_TEST        = 2'b10,
        MODE_EXPANDED    = 2'b11
    } op_mode_t;

    // bus phase sequencing: address phase (phase clock low) then data phase
    typedef enum logic [1:0] {
        PH_IDLE    = 2'b00,
        PH_ADDRESS = 2'b01,
        PH_DATA    = 2'b10
    } bus_phase_t;

    // one core bus cycle request
    typedef struct packed {
        logic        valid;
        logic        write;
        logic        internal;
        logic        opcode_fetch;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } core_cycle_t;

    // pins of a three-state bidirectional port
    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
    } port_drive_t;

    localparam logic       IRQ_EDGE_RESET  = 1'b0;
    localparam logic       NMI_MASK_RESET  = 1'b1;
    localparam logic [7:0] BYTE_ZERO       = 8'h00;
    localparam logic [7:0] BYTE_ONES       = 8'hFF;
    localparam int         ADDR_HI_LSB     = 8;
    localparam int         RXD_BIT         = 0;
    localparam int         TXD_BIT         = 1;
    localparam int         MISO_BIT        = 2;
    localparam int         MOSI_BIT        = 3;
    localparam int         SCK_BIT         = 4;
    localparam int         SS_BIT          = 5;

endpackage

// file: test/far_side_model.sv
`timescale 1ns/1ps
module far_side_model
    import pin_mux_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [2:0]  raise,
    input  wire logic [2:0]  ack,
    input  wire logic        address_latch_strobe,
    input  wire logic        bus_phase_clock,
    input  wire logic [7:0]  high_port_out,
    input  wire port_drive_t mux_port_drive,
    output logic             maskable_request_line_n,
    output logic             nonmaskable_request_line_n,
    output logic [7:0]       mux_port_in,
    output logic [15:0]      latched_addr
);
    logic [2:0] hold_reg;
    logic [7:0] last_reg;
    logic [7:0] far_byte;

    // each source keeps its line low until acknowledged
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            hold_reg <= 3'h0;
            last_reg <= 8'h5A;
        end else begin
            hold_reg <= (hold_reg | raise) & ~ack;
            last_reg <= mux_port_in;
        end
        if (address_latch_strobe) begin
            latched_addr <= {high_port_out, mux_port_drive.out};
        end
    end

    // open-drain lines, one pull-up each
    assign maskable_request_line_n    = ~(hold_reg[0] | hold_reg[1]);
    assign nonmaskable_request_line_n = ~hold_reg[2];
    // read data in data phase, else a pattern that keeps changing
    assign far_byte    = (bus_phase_clock && mux_port_drive.oe == 8'h00) ? ~latched_addr[7:0]
                                                                         : ~last_reg;
    assign mux_port_in = (mux_port_drive.oe & mux_port_drive.out)
                       | (~mux_port_drive.oe & far_byte);
endmodule

// file: test/tb.sv
`timescale 1ns/1ps
module tb;
    import pin_mux_pkg::*;
    logic        clk = 1'b0, rst_n = 1'b0, mode_select_pin_a = 1'b0, mode_select_pin_b = 1'b0;
    logic        irq_edge_select = 1'b0, irq_edge_write = 1'b0, irq_mask = 1'b0;
    logic        nmi_mask_clear = 1'b0, irq_taken = 1'b0, nmi_taken = 1'b0;
    logic        internal_read_visibility = 1'b0;
    core_cycle_t core_cycle = '0;
    logic [7:0]  internal_rdata = 8'h00;
    logic [62:0] rv = '0, p = '0;
    logic [2:0]  raise = 3'h0, ack = 3'h0, timer_port_in, capture_input;
    logic        gp_strobe_out, handshake_strobe_in, serial_enable, serial_txd, serial_mosi;
    logic        serial_sck, serial_miso, serial_dir_mosi_oe, serial_dir_sck_oe;
    logic        serial_dir_miso_oe, maskable_request_line_n, nonmaskable_request_line_n;
    logic        irq_request, nmi_request, irq_edge_mode, nmi_mask_flag, address_latch_strobe;
    logic        instruction_start_marker_oe, instruction_start_marker_out, strobe_out_pin;
    logic        address_latch_strobe_oe, strobe_in_level, bus_phase_clock, serial_rxd;
    logic        serial_miso_in, serial_mosi_in, serial_sck_in, serial_ss_n;
    logic [7:0]  gp_high_out, converter_port_in, mux_port_in, high_port_out, mux_data_in;
    logic [7:0]  converter_inputs, mi;
    port_drive_t gp_mux_drive, mux_port_drive;
    logic [5:0]  gp_serial_out, gp_serial_oe, serial_port_in, serial_port_out, serial_port_oe;
    op_mode_t    op_mode;
    logic [15:0] latched_addr;
    logic [31:0] seed = 32'hB479F35D;
    logic [62:0] hist[$];
    int          fails = 0, n_tests = 0, live = 0;

    assign {converter_port_in, serial_port_in, gp_serial_oe, gp_serial_out, serial_dir_miso_oe,
            serial_dir_sck_oe, serial_dir_mosi_oe, serial_miso, serial_sck, serial_mosi,
            serial_txd, serial_enable, timer_port_in, handshake_strobe_in, gp_mux_drive,
            gp_high_out, gp_strobe_out} = rv;

    mode_pin_mux_and_irq_inputs mode_pin_mux_and_irq_inputs_inst (.*);
    far_side_model far_side_model_inst (.*);

    always #10 clk = ~clk;

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic tick();
        @(posedge clk);
        #1;
    endtask

    task automatic chk(input logic [31:0] got, exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic test_done();
        if (fails == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic do_reset(input logic [1:0] m);
        rst_n = 1'b0;
        {mode_select_pin_b, mode_select_pin_a} = m;
        repeat (16) tick();
        rst_n = 1'b1;
        repeat (2) tick();
    endtask

    // one core cycle: address phase, then data phase
    task automatic bus(input logic w, it, op, input logic [15:0] a, input logic [7:0] d);
        logic vis;
        vis = !w && it && internal_read_visibility && op_mode == MODE_TEST;
        core_cycle = {1'b1, w, it, op, a, d};
        tick();
        core_cycle.valid = 1'b0;
        chk({address_latch_strobe, instruction_start_marker_oe}, {1'b1, op});
        chk({high_port_out, mux_port_drive}, {a, 8'hFF});
        chk(strobe_out_pin, !w);
        tick();
        chk({bus_phase_clock, address_latch_strobe, strobe_out_pin}, {2'b10, !w});
        chk(instruction_start_marker_oe, op);
        chk(mux_port_drive.oe, (w || vis) ? 8'hFF : 8'h00);
        if (w || vis) chk(mux_port_drive.out, w ? d : internal_rdata);
        chk(latched_addr, a);
    endtask

    task automatic ev(input logic [2:0] r, k, t);
        raise = r;
        ack = k;
        {nmi_mask_clear, nmi_taken, irq_taken} = t;
        tick();
        raise = 3'h0;
        ack = 3'h0;
        {nmi_mask_clear, nmi_taken, irq_taken} = 3'h0;
        repeat (3) tick();
    endtask

    // registered pin functions follow last cycle's random inputs
    always begin
        @(posedge clk);
        live = rst_n ? live + 1 : 0;
        #1;
        if (hist.size() > 0) p = hist.pop_front();
        if (live > 2) begin
            chk(converter_inputs, p[62:55]);
            chk(mux_data_in, mi);
            chk(instruction_start_marker_out, 1'b0);
            chk(capture_input, {p[26], p[27], p[28]});
            chk(address_latch_strobe_oe, op_mode[1]);
            if (p[29]) begin
                chk({serial_ss_n, serial_sck_in, serial_mosi_in, serial_miso_in, serial_rxd},
                    {p[54:51], p[49]});
                chk({serial_port_oe[4:1], serial_port_out[4:1]},
                    {p[35], p[34], p[36], 1'b1, p[32], p[31], p[33], p[30]});
            end else begin
                chk({serial_port_oe, serial_port_out}, p[48:37]);
            end
            if (!op_mode[1]) begin
                chk({mux_port_drive, high_port_out}, p[24:1]);
                chk({strobe_in_level, strobe_out_pin}, {p[25], p[0]});
            end else begin
                chk(strobe_in_level, 1'b0);
            end
        end
        rv = {31'(xs()), xs()};
        hist.push_back(rv);
        mi = mux_port_in;
    end

    initial begin
        #40000;
        fails++;
        test_done();
    end

    initial begin
        for (int m = 0; m < 4; m++) begin
            do_reset(2'(m));
            chk(op_mode, m);
            {mode_select_pin_b, mode_select_pin_a} = 2'(~m);
            tick();
            chk({op_mode, irq_edge_mode, nmi_mask_flag}, {2'(m), 2'b01});
            if (m >= 2) begin
                internal_read_visibility = 1'b1;
                internal_rdata = 8'(xs());
                bus(1'b0, 1'b1, 1'b1, 16'(xs()), 8'h00);
                bus(1'b1, 1'b0, 1'b0, 16'(xs()), 8'(xs()));
                bus(1'b1, 1'b0, 1'b0, 16'(xs()), 8'(xs()));
                bus(1'b0, 1'b0, 1'b1, 16'(xs()), 8'h00);
                internal_read_visibility = 1'b0;
            end
            repeat (20) tick();
        end
        ev(3'b011, 3'h0, 3'h0);
        chk(irq_request, 1'b1);
        ev(3'h0, 3'b001, 3'b001);
        chk(irq_request, 1'b1);
        irq_mask = 1'b1;
        ev(3'h0, 3'h0, 3'h0);
        chk(irq_request, 1'b0);
        irq_mask = 1'b0;
        ev(3'h0, 3'h0, 3'h0);
        chk(irq_request, 1'b1);
        ev(3'h0, 3'b010, 3'h0);
        chk(irq_request, 1'b0);
        irq_edge_select = 1'b1;
        irq_edge_write = 1'b1;
        tick();
        irq_edge_write = 1'b0;
        ev(3'b001, 3'h0, 3'h0);
        chk({irq_edge_mode, irq_request}, 2'b11);
        ev(3'h0, 3'h0, 3'b001);
        chk(irq_request, 1'b0);
        ev(3'h0, 3'b001, 3'h0);
        ev(3'b001, 3'h0, 3'h0);
        ev(3'h0, 3'b001, 3'h0);
        chk(irq_request, 1'b1);
        ev(3'h0, 3'h0, 3'b001);
        chk(irq_request, 1'b0);
        ev(3'b100, 3'h0, 3'h0);
        chk(nmi_request, 1'b0);
        ev(3'h0, 3'h0, 3'b100);
        chk({nmi_mask_flag, nmi_request}, 2'b01);
        ev(3'h0, 3'b100, 3'b010);
        chk(nmi_request, 1'b0);
        do_reset(2'b01);
        chk({irq_edge_mode, nmi_mask_flag, op_mode}, {2'b01, MODE_SINGLE_CHIP});
        repeat (20) tick();
        test_done();
    end
endmodule
